// ### src/ebps_pin_share.sv
// Purpose: sharing of address line 16 and data lines 0-6 with port B/F lines
// Assumes: pins and straps are asynchronous and pass two flip-flops
// Notes: pin drive is registered, one cycle behind its cause
`include "ebps_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Port B line 0 is a software-directed input or output.
// - Address line 16 floats when the bus idles, unless drive-hold is set.
// - After reset, boot straps and flash security choose line 0 start function.
// - A port B peripheral-enable write overrides the start-up choice.
// - Clearing port B pull-up bit 0 disables that line's pull-up.
// - Data lines 0-6 float when the bus idles, unless drive-hold is set.
// - Each of the seven shared port F lines is individually input or output.
// - Reset gives the seven port F lines the data bus function.
// - Clearing a port F pull-up bit disables the pull-up of that line.
module ebps_pin_share (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Memory interface side
  input wire ebps_pkg::ebps_bus_t busIn,
  output logic [6:0] busDataIn,
  output logic ctrlOe,
  // Boot straps
  input wire logic externalBootSelect,
  input wire logic memoryInterfaceMode,
  input wire logic flashSecured,
  // Shared pins
  input wire logic portBLine0In,
  input wire logic [6:0] portFIn,
  output ebps_pkg::ebps_drive_t pinDrive,
  output logic portBPullup,
  output logic [6:0] portFPullup
);
  // ********************
  // Synchronisers
  // ********************
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  logic [10:0] syncIn;

  assign syncIn = {externalBootSelect, memoryInterfaceMode, flashSecured,
                   portBLine0In, portFIn};

  // Two stages on every pin and strap; only stage two is read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 11'h000;
      sync2_r <= 11'h000;
    end else begin
      sync1_r <= syncIn;
      sync2_r <= sync1_r;
    end
  end

  logic bootExt, bootMode, bootSec, pinB;
  logic [6:0] pinF;
  assign {bootExt, bootMode, bootSec, pinB, pinF} = sync2_r;
  assign busDataIn = pinF;

  // ********************
  // Registers
  // ********************
  logic drv_r, drv_nxt;
  logic perB_r, perB_nxt;
  logic ddrB_r, ddrB_nxt;
  logic doutB_r, doutB_nxt;
  logic purB_r, purB_nxt;
  logic [6:0] perF_r, perF_nxt;
  logic [6:0] ddrF_r, ddrF_nxt;
  logic [6:0] doutF_r, doutF_nxt;
  logic [6:0] purF_r, purF_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [1:0] waitCnt_r, waitCnt_nxt;
  logic bootAddr_r, bootAddr_nxt;
  logic perBWritten_r, perBWritten_nxt;
  ebps_pkg::ebps_start_t start_r, start_nxt;
  logic wrHit;
  logic [6:0] wF;

  assign wF = regWdata[`EBPS_F_HI:`EBPS_F_LO];

  // Start function: bus address when booting externally or in bus mode,
  // but never when the flash is secured, so secure code stays hidden
  logic strapAddr;
  assign strapAddr = (bootExt | bootMode) & ~bootSec;

  // Next register state, write decode and start-up sequencing
  always_comb begin
    drv_nxt = drv_r;
    perB_nxt = perB_r;
    ddrB_nxt = ddrB_r;
    doutB_nxt = doutB_r;
    purB_nxt = purB_r;
    perF_nxt = perF_r;
    ddrF_nxt = ddrF_r;
    doutF_nxt = doutF_r;
    purF_nxt = purF_r;
    waitCnt_nxt = waitCnt_r;
    bootAddr_nxt = bootAddr_r;
    perBWritten_nxt = perBWritten_r;
    start_nxt = start_r;
    wrHit = 1'b0;
    // Straps reach stage two two edges after release; sample them then
    unique case (start_r)
      ebps_pkg::EBPS_WAIT: begin
        if (waitCnt_r == `EBPS_STRAP_WAIT) begin
          start_nxt = ebps_pkg::EBPS_DONE;
          bootAddr_nxt = strapAddr;
          if (!perBWritten_r) begin
            perB_nxt = strapAddr;
          end
        end else begin
          waitCnt_nxt = waitCnt_r + 2'h1;
        end
      end
      ebps_pkg::EBPS_DONE: begin
        waitCnt_nxt = waitCnt_r;
      end
    endcase
    if (regWrite) begin
      wrHit = 1'b1;
      unique case (regAddr)
        `EBPS_BUS_CONTROL_REG: drv_nxt = regWdata[`EBPS_DRV_BIT];
        `EBPS_B_PER: begin
          perB_nxt = regWdata[`EBPS_B_LINE];
          perBWritten_nxt = 1'b1;
        end
        `EBPS_B_DDR: ddrB_nxt = regWdata[`EBPS_B_LINE];
        `EBPS_B_DOUT: doutB_nxt = regWdata[`EBPS_B_LINE];
        `EBPS_B_PUR: purB_nxt = regWdata[`EBPS_B_LINE];
        `EBPS_F_PER: perF_nxt = wF;
        `EBPS_F_DDR: ddrF_nxt = wF;
        `EBPS_F_DOUT: doutF_nxt = wF;
        `EBPS_F_PUR: purF_nxt = wF;
        default: wrHit = 1'b0;
      endcase
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        `EBPS_BUS_CONTROL_REG: rdata_nxt[`EBPS_DRV_BIT] = drv_r;
        `EBPS_B_PER: rdata_nxt[`EBPS_B_LINE] = perB_r;
        `EBPS_B_DDR: rdata_nxt[`EBPS_B_LINE] = ddrB_r;
        `EBPS_B_DOUT: rdata_nxt[`EBPS_B_LINE] = doutB_r;
        `EBPS_B_DIN: rdata_nxt[`EBPS_B_LINE] = pinB;
        `EBPS_B_PUR: rdata_nxt[`EBPS_B_LINE] = purB_r;
        `EBPS_F_PER: rdata_nxt[`EBPS_F_HI:`EBPS_F_LO] = perF_r;
        `EBPS_F_DDR: rdata_nxt[`EBPS_F_HI:`EBPS_F_LO] = ddrF_r;
        `EBPS_F_DOUT: rdata_nxt[`EBPS_F_HI:`EBPS_F_LO] = doutF_r;
        `EBPS_F_DIN: rdata_nxt[`EBPS_F_HI:`EBPS_F_LO] = pinF;
        `EBPS_F_PUR: rdata_nxt[`EBPS_F_HI:`EBPS_F_LO] = purF_r;
        `EBPS_STATUS: begin
          rdata_nxt[`EBPS_ST_ACTIVE] = busIn.active;
          rdata_nxt[`EBPS_ST_BOOTADDR] = bootAddr_r;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register stage; GPIO lines start as inputs with pull-ups on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drv_r <= `EBPS_DRV_RST;
      perB_r <= 1'b0;
      ddrB_r <= 1'b0;
      doutB_r <= 1'b0;
      purB_r <= 1'b1;
      perF_r <= `EBPS_F_PER_RST;
      ddrF_r <= 7'h00;
      doutF_r <= 7'h00;
      purF_r <= `EBPS_PUR_RST;
      rdata_r <= 16'h0000;
      waitCnt_r <= 2'h0;
      bootAddr_r <= 1'b0;
      perBWritten_r <= 1'b0;
      start_r <= ebps_pkg::EBPS_WAIT;
    end else begin
      drv_r <= drv_nxt;
      perB_r <= perB_nxt;
      ddrB_r <= ddrB_nxt;
      doutB_r <= doutB_nxt;
      purB_r <= purB_nxt;
      perF_r <= perF_nxt;
      ddrF_r <= ddrF_nxt;
      doutF_r <= doutF_nxt;
      purF_r <= purF_nxt;
      rdata_r <= rdata_nxt;
      waitCnt_r <= waitCnt_nxt;
      bootAddr_r <= bootAddr_nxt;
      perBWritten_r <= perBWritten_nxt;
      start_r <= start_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign portBPullup = purB_r;
  assign portFPullup = purF_r;

  // ********************
  // Pin drive
  // ********************
  ebps_pkg::ebps_drive_t drive_r, drive_nxt;
  logic idleHold;

  // Drive-hold keeps idle pins driven; default floats them
  assign idleHold = busIn.active | drv_r;
  assign ctrlOe = idleHold;

  // Bus function when the enable bit is set, GPIO otherwise
  always_comb begin
    drive_nxt.bOut = perB_r ? busIn.addr16 : doutB_r;
    drive_nxt.bOe = perB_r ? idleHold : ddrB_r;
    drive_nxt.fOut = (perF_r & busIn.dataOut) | (~perF_r & doutF_r);
    // Reads turn the data lines round while the bus is active
    if (busIn.active) begin
      drive_nxt.fOe = (perF_r & {7{busIn.dataOe}}) | (~perF_r & ddrF_r);
    end else begin
      drive_nxt.fOe = (perF_r & {7{drv_r}}) | (~perF_r & ddrF_r);
    end
  end

  // Registered so the pads see no decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign pinDrive = drive_r;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence wrSeq(logic [3:0] a);
    regWrite && regAddr == a;
  endsequence

  logic fPerTouched_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fPerTouched_r <= 1'b0;
    end else if (regWrite && regAddr == `EBPS_F_PER) begin
      fPerTouched_r <= 1'b1;
    end
  end

  gpio_b_dir_a: assert property (!perB_r |=> pinDrive.bOe == $past(ddrB_r))
    else $error("port B line 0 direction not from its direction bit");
  addr_idle_float_a: assert property (perB_r && !busIn.active && !drv_r |=> !pinDrive.bOe)
    else $error("address line 16 driven while bus idle without drive-hold");
  strap_choice_a: assert property (start_r == ebps_pkg::EBPS_WAIT
      && waitCnt_r == `EBPS_STRAP_WAIT && !perBWritten_r && !regWrite
      |=> perB_r == $past(strapAddr))
    else $error("start function not taken from the straps");
  per_write_a: assert property (wrSeq(`EBPS_B_PER) |=> perB_r == $past(regWdata[0]))
    else $error("port B enable write lost");
  pullup_b_a: assert property (wrSeq(`EBPS_B_PUR) |=> portBPullup == $past(regWdata[0]))
    else $error("port B pull-up does not follow the write");
  // Control outputs float with the bus idle unless drive-hold keeps them up
  ctrl_oe_a: assert property (ctrlOe == (busIn.active | drv_r))
    else $error("control output enable not from bus activity and drive-hold");
  addr_hold_a: assert property (perB_r && drv_r |=> pinDrive.bOe)
    else $error("address line 16 released although drive-hold is set");
  // Bus function during a running cycle follows the turn-round request
  data_bus_dir_a: assert property (busIn.active && perF_r == 7'h7F
      |=> pinDrive.fOe == {7{$past(busIn.dataOe)}})
    else $error("data lines in bus function ignore the turn-round request");
  data_idle_float_a: assert property (!busIn.active && !drv_r |=> (pinDrive.fOe & $past(perF_r)) == 7'h00)
    else $error("data lines driven while bus idle without drive-hold");
  f_reset_bus_a: assert property (!fPerTouched_r |-> perF_r == `EBPS_F_PER_RST)
    else $error("port F lines left the bus function without a write");
  pullup_f_a: assert property (wrSeq(`EBPS_F_PUR) |=> portFPullup == $past(regWdata[15:9]))
    else $error("port F pull-up does not follow the write");
  bus_addr_a: assert property (perB_r |=> pinDrive.bOut == $past(busIn.addr16))
    else $error("address line 16 not carried in bus function");
  f_gpio_dir_a: assert property (perF_r == 7'h00 |=> pinDrive.fOe == $past(ddrF_r))
    else $error("port F direction not from direction bits");
endmodule

`default_nettype wire

// ### src/ebps_defs.svh
// Purpose: offsets, field positions, reset values and counts for the pin-sharing block
// Assumes: 16-bit register port, word indices on a 4-bit address
// Notes: definitions only
`ifndef EBPS_DEFS_SVH
`define EBPS_DEFS_SVH
// ********************
// Register offsets
// ********************
`define EBPS_BUS_CONTROL_REG 4'h0
`define EBPS_B_PER 4'h1
`define EBPS_B_DDR 4'h2
`define EBPS_B_DOUT 4'h3
`define EBPS_B_DIN 4'h4
`define EBPS_B_PUR 4'h5
`define EBPS_F_PER 4'h6
`define EBPS_F_DDR 4'h7
`define EBPS_F_DOUT 4'h8
`define EBPS_F_DIN 4'h9
`define EBPS_F_PUR 4'hA
`define EBPS_STATUS 4'hB
// ********************
// Field positions
// ********************
`define EBPS_DRV_BIT 0
`define EBPS_B_LINE 0
`define EBPS_F_LO 9
`define EBPS_F_HI 15
`define EBPS_ST_ACTIVE 0
`define EBPS_ST_BOOTADDR 1
// ********************
// Reset values
// ********************
`define EBPS_DRV_RST 1'h0
`define EBPS_F_PER_RST 7'h7F
`define EBPS_PUR_RST 7'h7F
// ********************
// Timing counts
// ********************
`define EBPS_STRAP_WAIT 2'h2
`endif

// ### src/ebps_pkg.sv
// Purpose: shared types of the pin-sharing block
// Assumes: seven shared port F lines
// Notes: constants live in ebps_defs.svh
package ebps_pkg;
  // Signals handed over by the memory interface
  typedef struct packed {
    logic active;
    logic addr16;
    logic dataOe;
    logic [6:0] dataOut;
  } ebps_bus_t;
  // Drive of the eight shared pins
  typedef struct packed {
    logic bOut;
    logic bOe;
    logic [6:0] fOut;
    logic [6:0] fOe;
  } ebps_drive_t;
  // Start-up sequencer
  typedef enum logic [1:0] {EBPS_WAIT, EBPS_DONE} ebps_start_t;
endpackage

// ### verif/ebps_mem_model.sv
// Purpose: external memory seen from the shared pins
// Assumes: memory drives the lines only while memOe is high
// Notes: released lines without pull-up toggle, so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module ebps_mem_model (
  // Clock
  input wire logic clock,
  // Device side
  input wire ebps_pkg::ebps_drive_t drive,
  input wire logic bPull,
  input wire logic [6:0] fPull,
  // Memory side
  input wire logic memOe,
  input wire logic [7:0] memData,
  // Resolved pins
  output logic bPin,
  output logic [6:0] fPin
);
  logic flip = 1'b0;
  // Free lines drift each cycle unless pulled up
  always @(posedge clock) flip <= ~flip;
  // Device wins when enabled, then the memory, then pull-up or drift
  always_comb begin
    bPin = drive.bOe ? drive.bOut : memOe ? memData[7] : bPull | flip;
    for (int k = 0; k < 7; k++) begin
      fPin[k] = drive.fOe[k] ? drive.fOut[k] : memOe ? memData[k] : fPull[k] | flip;
    end
  end
endmodule
`default_nettype wire

// ### verif/test_ext_bus_pin_sharing.sv
// Purpose: random and corner checks of pin sharing
// Assumes: strap changes only while reset is held
// Notes: expected drive is rebuilt from the register values written
`include "ebps_defs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_ext_bus_pin_sharing;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdata;
  ebps_pkg::ebps_bus_t busIn = '0;
  ebps_pkg::ebps_drive_t pinDrive;
  logic [6:0] busDataIn, portFIn, portFPullup;
  logic ctrlOe, portBLine0In, portBPullup;
  logic external_boot_select = 1'b0, emiMode = 1'b0, secured = 1'b0, memOe = 1'b0;
  logic [7:0] memData = 8'h00;
  logic [31:0] rnd;
  logic perB, drv, ddrB, doutB;
  logic [6:0] perF, ddrF, doutF, purF;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 51883;

  always #2.5 clock = ~clock;

  ebps_pin_share dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .busIn(busIn),
    .busDataIn(busDataIn), .ctrlOe(ctrlOe), .externalBootSelect(external_boot_select),
    .memoryInterfaceMode(emiMode), .flashSecured(secured), .portBLine0In(portBLine0In),
    .portFIn(portFIn), .pinDrive(pinDrive), .portBPullup(portBPullup),
    .portFPullup(portFPullup));
  ebps_mem_model model (.clock(clock), .drive(pinDrive), .bPull(portBPullup),
    .fPull(portFPullup), .memOe(memOe), .memData(memData), .bPin(portBLine0In),
    .fPin(portFIn));

  // ****
  // Bus tasks
  // ****
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] ex, input string nm);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    `CHK(nm, ex, regRdata)
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Pin drive expected from the written registers and the bus inputs
  function automatic ebps_pkg::ebps_drive_t expDrive();
    ebps_pkg::ebps_drive_t e;
    e.bOut = perB ? busIn.addr16 : doutB;
    e.bOe = perB ? (busIn.active | drv) : ddrB;
    for (int k = 0; k < 7; k++) begin
      e.fOut[k] = perF[k] ? busIn.dataOut[k] : doutF[k];
      e.fOe[k] = perF[k] ? (busIn.active ? busIn.dataOe : drv) : ddrF[k];
    end
    return e;
  endfunction

  // Hang guard
  initial begin
    repeat (50000) @(posedge clock);
    error_cnt++;
    stop_test();
  end

  initial begin
    // One reset per strap combination
    for (int i = 0; i < 8; i++) begin
      {external_boot_select, emiMode, secured} <= i[2:0];
      do_reset();
      rd(`EBPS_B_PER, {15'h0000, (i[2] | i[1]) & ~i[0]}, "startup");
      rd(`EBPS_STATUS, {14'h0000, (i[2] | i[1]) & ~i[0], 1'b0}, "status");
    end
    rd(`EBPS_F_PER, 16'hFE00, "f_per_rst");
    rd(`EBPS_F_PUR, 16'hFE00, "f_pur_rst");
    rd(`EBPS_BUS_CONTROL_REG, 16'h0000, "drv_rst");
    rd(4'hD, 16'h0000, "unmapped");
    `CHK("b_pull_rst", 1'b1, portBPullup)
    $display("test reset done");
    // First four passes: bus idle, bus function, drive-hold off, on, off, on
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      perB = rnd[0] | (i < 4);
      drv = (i < 4) ? i[0] : rnd[1];
      ddrB = rnd[2];
      doutB = rnd[3];
      perF = (i < 4) ? 7'h7F : rnd[10:4];
      ddrF = rnd[17:11];
      doutF = rnd[24:18];
      purF = rnd[31:25];
      wr(`EBPS_BUS_CONTROL_REG, {15'h0000, drv});
      wr(`EBPS_B_PER, {15'h0000, perB});
      wr(`EBPS_B_DDR, {15'h0000, ddrB});
      wr(`EBPS_B_DOUT, {15'h0000, doutB});
      wr(`EBPS_B_PUR, {15'h0000, purF[0]});
      wr(`EBPS_F_PER, {perF, 9'h000});
      wr(`EBPS_F_DDR, {ddrF, 9'h000});
      wr(`EBPS_F_DOUT, {doutF, 9'h000});
      wr(`EBPS_F_PUR, {purF, 9'h000});
      rnd = $random(seed);
      busIn <= (i < 4) ? 10'h000 : rnd[9:0];
      memOe <= rnd[10];
      memData <= rnd[18:11];
      repeat (3) @(posedge clock);
      @(negedge clock);
      `CHK("drive", expDrive(), pinDrive)
      `CHK("ctrl_oe", busIn.active | drv, ctrlOe)
      `CHK("b_pull", purF[0], portBPullup)
      `CHK("f_pull", purF, portFPullup)
      rd(`EBPS_B_PER, {15'h0000, perB}, "b_per");
      if (memOe === 1'b1) begin
        `CHK("bus_din", portFIn, busDataIn)
        rd(`EBPS_F_DIN, {portFIn, 9'h000}, "f_din");
        rd(`EBPS_B_DIN, {15'h0000, portBLine0In}, "b_din");
      end
    end
    $display("test random done");
    stop_test();
  end
endmodule
`default_nettype wire
